// ===== fsd_diag.sv
// Slave diagnostic bytes and malfunction code of a laser measuring device.
// Assumes one 100 MHz clock, a synchronous reset and a classic Wishbone
// master; protocol engine events arrive as one-cycle pulses.
//
// The implementer's own choices: the address map and register access over Wishbone.
`timescale 1ns/100ps

// Summary of operation
// - Parameter-fault flag, status byte 1 bit 6, set when parameterization rejected.
// - Unsupported-function flag, status byte 1 bit 4, set on unsupported request.
// - Extended-diagnosis flag, status byte 1 bit 3, follows pending extended diagnosis.
// - Configuration fault flag, status byte 1 bit 2, set on rejected identifiers.
// - Not-ready flag, status byte 1 bit 1, while cyclic exchange impossible.
// - Sync and freeze flags, status byte 2 bits 5 and 4, on commands.
// - Status byte 2 bit 3 shows response watchdog active.
// - Status byte 2 bit 2 always reads one.
// - Status byte 2 bit 0 requests reparameterization when needed.
// - Status byte 3 bit 7 flags extended overflow; bits 6-0 reserved.
// - Byte 4 holds address of first master with valid parameterization.
// - Bytes 5 and 6 return fixed 16-bit device-type identifier.
// - Identifier high byte goes in byte 5, low byte in byte 6.
// - Malfunction bit 0 set when intensity below minimum.
// - Malfunction bit 1 set when housing temperature leaves 0 to 50 degC.
// - Malfunction bit 2 on hardware error or station address below 3.
// - Malfunction bit 3 informs that laser is switched off.
// - Malfunction bit 4 warns below 12 percent intensity; measurement continues.
// - Malfunction bits 5, 6, 7: speed, plausibility, switching position warnings.
// - Optionally hold malfunction code until acknowledged by control bit or input.
module fsd_diag (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Protocol engine events
  input wire logic prm_ok_i,
  input wire logic prm_rej_i,
  input wire logic [7:0] prm_master_i,
  input wire logic cfg_ok_i,
  input wire logic cfg_rej_i,
  input wire logic unsupp_i,
  input wire logic sync_cmd_i,
  input wire logic unsync_cmd_i,
  input wire logic freeze_cmd_i,
  input wire logic unfreeze_cmd_i,
  input wire logic data_exch_i,
  input wire logic ext_diag_pend_i,
  input wire logic ext_diag_ovf_i,
  input wire logic diag_read_i,
  // Measurement conditions
  input wire logic intens_low_i,
  input wire logic [7:0] intens_pct_i,
  input wire logic [7:0] temp_c_i,
  input wire logic hw_err_i,
  input wire logic laser_off_in_i,
  input wire logic speed_over_i,
  input wire logic plaus_bad_i,
  input wire logic switch_pass_i,
  input wire logic ack_in_i,
  // Diagnostic outputs
  output logic [7:0] stat1_o,
  output logic [7:0] stat2_o,
  output logic [7:0] stat3_o,
  output logic [7:0] master_addr_o,
  output logic [7:0] ident_hi_o,
  output logic [7:0] ident_lo_o,
  output logic [7:0] malf_code_o,
  output logic response_watchdog_active_o
);
  import fsd_pkg::*;

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic prm_fault_ff;
  logic not_supp_ff;
  logic cfg_fault_ff;
  logic sync_ff;
  logic freeze_ff;
  logic prm_req_ff;
  logic ovf_ff;
  logic prm_done_ff;
  logic cfg_done_ff;
  logic [3:0] ctrl_ff;
  logic [7:0] addr_ff;
  logic [7:0] malf_ff;
  logic [7:0] stat1_ff;
  logic [7:0] stat2_ff;
  logic [7:0] stat3_ff;
  logic [7:0] master_ff;
  logic [7:0] malf_out_ff;
  logic wdog_out_ff;
  logic ack_ff;
  logic [31:0] rdat_ff;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  wire bus_req = wb_cyc_i & wb_stb_i & ~ack_ff;
  wire bus_wr = bus_req & wb_we_i & wb_sel_i[0];
  wire wr_ctrl = bus_wr & (wb_adr_i == FSD_OFS_CTRL);
  wire wr_ack = bus_wr & (wb_adr_i == FSD_OFS_ACK) & wb_dat_i[0];
  wire wr_addr = bus_wr & (wb_adr_i == FSD_OFS_ADDR);
  wire hold_en = ctrl_ff[FSD_CTRL_HOLD];
  wire wdog_on = ctrl_ff[FSD_CTRL_WDOG];

  // ----------------------------------------------------------------------
  // Malfunction conditions
  // ----------------------------------------------------------------------
  wire temp_bad = (temp_c_i < FSD_TEMP_MIN) | (temp_c_i > FSD_TEMP_MAX);
  wire addr_bad = addr_ff < FSD_MIN_STATION;
  wire laser_off = ctrl_ff[FSD_CTRL_LASER_OFF] | laser_off_in_i;
  wire hw_bad = hw_err_i | ctrl_ff[FSD_CTRL_HW_ERR] | addr_bad;
  wire int_warn = intens_pct_i < FSD_INT_WARN_PCT;
  logic [7:0] malf_now;
  always_comb begin
    malf_now = 8'h00;
    malf_now[FSD_MF_INTENS] = intens_low_i;
    malf_now[FSD_MF_TEMP] = temp_bad;
    malf_now[FSD_MF_HW] = hw_bad;
    malf_now[FSD_MF_LASER_OFF] = laser_off;
    malf_now[FSD_MF_INT_WARN] = int_warn;
    malf_now[FSD_MF_SPEED] = speed_over_i;
    malf_now[FSD_MF_PLAUS] = plaus_bad_i;
    malf_now[FSD_MF_SWITCH] = switch_pass_i;
  end

  // Latched code: present conditions always win over the acknowledge
  wire malf_clr = wr_ack | ack_in_i;
  wire [7:0] nxt_malf = hold_en ?
    (malf_now | (malf_clr ? 8'h00 : malf_ff)) : malf_now;

  // ----------------------------------------------------------------------
  // Station status assembly
  // ----------------------------------------------------------------------
  wire not_ready = ~(prm_done_ff & cfg_done_ff & data_exch_i);
  logic [7:0] nxt_stat1;
  logic [7:0] nxt_stat2;
  logic [7:0] nxt_stat3;
  always_comb begin
    nxt_stat1 = 8'h00;
    nxt_stat1[FSD_S1_PRM_FAULT] = prm_fault_ff;
    nxt_stat1[FSD_S1_NOT_SUPP] = not_supp_ff;
    nxt_stat1[FSD_S1_EXT_DIAG] = ext_diag_pend_i;
    nxt_stat1[FSD_S1_CFG_FAULT] = cfg_fault_ff;
    nxt_stat1[FSD_S1_NOT_READY] = not_ready;
    nxt_stat2 = 8'h00;
    nxt_stat2[FSD_S2_SYNC] = sync_ff;
    nxt_stat2[FSD_S2_FREEZE] = freeze_ff;
    nxt_stat2[FSD_S2_WDOG] = wdog_on;
    nxt_stat2[FSD_S2_SLAVE] = 1'b1;
    nxt_stat2[FSD_S2_PRM_REQ] = prm_req_ff;
    nxt_stat3 = 8'h00;
    nxt_stat3[FSD_S3_OVERFLOW] = ovf_ff;
  end

  // ----------------------------------------------------------------------
  // Event flags
  // ----------------------------------------------------------------------
  // Unsupported and overflow flags drop when the master reads diagnosis, parameter and
  // configuration faults on their accept event; a new event in the same cycle keeps its flag set.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prm_fault_ff <= 1'b0;
      not_supp_ff <= 1'b0;
      cfg_fault_ff <= 1'b0;
      ovf_ff <= 1'b0;
    end else begin
      prm_fault_ff <= prm_rej_i | (prm_fault_ff & ~prm_ok_i);
      not_supp_ff <= unsupp_i | (not_supp_ff & ~diag_read_i);
      cfg_fault_ff <= cfg_rej_i | (cfg_fault_ff & ~cfg_ok_i);
      ovf_ff <= ext_diag_ovf_i | (ovf_ff & ~diag_read_i);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_ff <= 1'b0;
      freeze_ff <= 1'b0;
    end else begin
      sync_ff <= sync_cmd_i | (sync_ff & ~unsync_cmd_i);
      freeze_ff <= freeze_cmd_i | (freeze_ff & ~unfreeze_cmd_i);
    end
  end

  // Parameterization progress; any rejection asks for a new round
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prm_done_ff <= 1'b0;
      cfg_done_ff <= 1'b0;
      prm_req_ff <= 1'b1;
    end else begin
      prm_done_ff <= prm_ok_i | (prm_done_ff & ~prm_rej_i);
      cfg_done_ff <= (cfg_ok_i | (cfg_done_ff & ~cfg_rej_i)) & ~prm_rej_i;
      prm_req_ff <= prm_rej_i | cfg_rej_i |
        (prm_req_ff & ~(cfg_ok_i & prm_done_ff));
    end
  end

  // First master with a valid parameterization is kept
  wire [7:0] nxt_master = (prm_ok_i & (master_ff == FSD_NO_MASTER)) ?
    prm_master_i : master_ff;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      master_ff <= FSD_NO_MASTER;
    end else begin
      master_ff <= nxt_master;
    end
  end

  // ----------------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_ff <= FSD_CTRL_RST;
      addr_ff <= FSD_ADDR_RST;
      malf_ff <= 8'h00;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= wb_dat_i[3:0];
      end
      if (wr_addr) begin
        addr_ff <= wb_dat_i[7:0];
      end
      malf_ff <= nxt_malf;
    end
  end

  // ----------------------------------------------------------------------
  // Read mux and acknowledge
  // ----------------------------------------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    case (wb_adr_i)
      FSD_OFS_DIAG0: rd_mux = {master_ff, stat3_ff, stat2_ff, stat1_ff};
      FSD_OFS_DIAG1: rd_mux = {16'h0000, ident_lo_o, ident_hi_o};
      FSD_OFS_CTRL: rd_mux = {28'h0000000, ctrl_ff};
      FSD_OFS_MALF: rd_mux = {24'h000000, malf_ff};
      FSD_OFS_ADDR: rd_mux = {24'h000000, addr_ff};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_ff <= 1'b0;
      rdat_ff <= 32'h00000000;
    end else begin
      ack_ff <= bus_req;
      rdat_ff <= bus_req ? rd_mux : 32'h00000000;
    end
  end

  // ----------------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stat1_ff <= FSD_STAT1_RST;
      stat2_ff <= FSD_STAT2_RST;
      stat3_ff <= 8'h00;
      malf_out_ff <= 8'h00;
      wdog_out_ff <= 1'b0;
      ident_hi_o <= 8'h00;
      ident_lo_o <= 8'h00;
    end else begin
      stat1_ff <= nxt_stat1;
      stat2_ff <= nxt_stat2;
      stat3_ff <= nxt_stat3;
      malf_out_ff <= nxt_malf;
      wdog_out_ff <= wdog_on;
      ident_hi_o <= FSD_IDENT[15:8];
      ident_lo_o <= FSD_IDENT[7:0];
    end
  end

  assign stat1_o = stat1_ff;
  assign stat2_o = stat2_ff;
  assign stat3_o = stat3_ff;
  assign master_addr_o = master_ff;
  assign malf_code_o = malf_out_ff;
  assign response_watchdog_active_o = wdog_out_ff;
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;

endmodule

// ===== fsd_pkg.sv
// Constants for the slave diagnostic block: register offsets, bit positions,
// reset values and limits.
// Assumes a 32-bit classic Wishbone register bus at 100 MHz.
package fsd_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] FSD_OFS_DIAG0 = 8'h00; // Station status bytes 1..3, master address byte 4
  localparam logic [7:0] FSD_OFS_DIAG1 = 8'h04; // Identifier bytes 5..6
  localparam logic [7:0] FSD_OFS_CTRL = 8'h08;
  localparam logic [7:0] FSD_OFS_MALF = 8'h0C;
  localparam logic [7:0] FSD_OFS_ACK = 8'h10;
  localparam logic [7:0] FSD_OFS_ADDR = 8'h14;

  // ----------------------------------------------------------------------
  // Station status 1 bit positions
  // ----------------------------------------------------------------------
  localparam int FSD_S1_PRM_FAULT = 6;
  localparam int FSD_S1_NOT_SUPP = 4;
  localparam int FSD_S1_EXT_DIAG = 3;
  localparam int FSD_S1_CFG_FAULT = 2;
  localparam int FSD_S1_NOT_READY = 1;

  // ----------------------------------------------------------------------
  // Station status 2 and 3 bit positions
  // ----------------------------------------------------------------------
  localparam int FSD_S2_SYNC = 5;
  localparam int FSD_S2_FREEZE = 4;
  localparam int FSD_S2_WDOG = 3;
  localparam int FSD_S2_SLAVE = 2;
  localparam int FSD_S2_PRM_REQ = 0;
  localparam int FSD_S3_OVERFLOW = 7;

  // ----------------------------------------------------------------------
  // Malfunction code bit positions
  // ----------------------------------------------------------------------
  localparam int FSD_MF_INTENS = 0;
  localparam int FSD_MF_TEMP = 1;
  localparam int FSD_MF_HW = 2;
  localparam int FSD_MF_LASER_OFF = 3;
  localparam int FSD_MF_INT_WARN = 4;
  localparam int FSD_MF_SPEED = 5;
  localparam int FSD_MF_PLAUS = 6;
  localparam int FSD_MF_SWITCH = 7;

  // ----------------------------------------------------------------------
  // Control register bit positions
  // ----------------------------------------------------------------------
  localparam int FSD_CTRL_HOLD = 0;
  localparam int FSD_CTRL_WDOG = 1;
  localparam int FSD_CTRL_LASER_OFF = 2;
  localparam int FSD_CTRL_HW_ERR = 3;

  // ----------------------------------------------------------------------
  // Reset values and limits
  // ----------------------------------------------------------------------
  localparam logic [7:0] FSD_MIN_STATION = 8'h03;
  localparam logic [7:0] FSD_MAX_STATION = 8'h63; // 99
  localparam logic [7:0] FSD_NO_MASTER = 8'hFF;
  localparam logic [7:0] FSD_TEMP_MIN = 8'h00; // 0 degC
  localparam logic [7:0] FSD_TEMP_MAX = 8'h32; // 50 degC
  localparam logic [7:0] FSD_INT_WARN_PCT = 8'h0C; // 12 percent
  localparam logic [3:0] FSD_CTRL_RST = 4'h0;
  localparam logic [7:0] FSD_STAT1_RST = 8'h02; // Not ready
  localparam logic [7:0] FSD_STAT2_RST = 8'h05; // Slave, parameter request
  localparam logic [7:0] FSD_ADDR_RST = 8'h00;
  // Arbitrary neutral device-type identifier
  localparam logic [15:0] FSD_IDENT = 16'hA5C3;

endpackage

// ===== fsd_diag_properties.sv
// Checker for the slave diagnostic block, bound to its top module.
// Assumes only the block's ports; one clock, synchronous reset.
`timescale 1ns/100ps
module fsd_diag_properties (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Events and conditions
  input wire logic prm_ok_i,
  input wire logic prm_rej_i,
  input wire logic unsupp_i,
  input wire logic ext_diag_pend_i,
  input wire logic hw_err_i,
  input wire logic [7:0] temp_c_i,
  // Diagnostic outputs
  input wire logic [7:0] stat1_o,
  input wire logic [7:0] stat2_o,
  input wire logic [7:0] stat3_o,
  input wire logic [7:0] ident_hi_o,
  input wire logic [7:0] ident_lo_o,
  input wire logic [7:0] malf_code_o
);
  import fsd_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_next: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not a single cycle");
  chk_prm_fault: assert property (
    prm_rej_i && !prm_ok_i |=> ##1 stat1_o[FSD_S1_PRM_FAULT])
    else $error("parameter fault flag not set");
  chk_unsupp_set: assert property (
    unsupp_i |=> ##1 stat1_o[FSD_S1_NOT_SUPP])
    else $error("unsupported flag not set");
  chk_ext_follow: assert property (
    ext_diag_pend_i [*3] |-> stat1_o[FSD_S1_EXT_DIAG])
    else $error("extended flag not following pending");
  chk_slave_one: assert property (
    stat2_o[FSD_S2_SLAVE])
    else $error("slave indicator low");
  chk_reserved_zero: assert property (
    {stat1_o[7], stat1_o[5], stat1_o[0], stat2_o[7:6], stat2_o[1],
     stat3_o[6:0]} == 13'h0000)
    else $error("reserved status bit set");
  chk_ident_fixed: assert property (
    !$past(rst_i) |-> {ident_hi_o, ident_lo_o} == FSD_IDENT)
    else $error("identifier bytes wrong");
  chk_temp_high: assert property (
    temp_c_i > FSD_TEMP_MAX |=> malf_code_o[FSD_MF_TEMP])
    else $error("temperature bit not set");
  chk_hw_error: assert property (
    hw_err_i |=> malf_code_o[FSD_MF_HW])
    else $error("hardware bit not set");
  cov_prm: cover property (stat1_o[FSD_S1_PRM_FAULT]);
  cov_ovf: cover property (stat3_o[FSD_S3_OVERFLOW]);
  cov_temp: cover property (malf_code_o[FSD_MF_TEMP]);
endmodule

bind fsd_diag fsd_diag_properties i_fsd_diag_properties (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .prm_ok_i(prm_ok_i), .prm_rej_i(prm_rej_i),
  .unsupp_i(unsupp_i), .ext_diag_pend_i(ext_diag_pend_i),
  .hw_err_i(hw_err_i), .temp_c_i(temp_c_i), .stat1_o(stat1_o),
  .stat2_o(stat2_o), .stat3_o(stat3_o), .ident_hi_o(ident_hi_o),
  .ident_lo_o(ident_lo_o), .malf_code_o(malf_code_o));

// ===== fsd_master_model.sv
// Fieldbus master stand-in issuing protocol events as one-cycle pulses.
// Assumes the bench calls pulse from one thread at a time.
`timescale 1ns/100ps
module fsd_master_model (
  // Clock
  input wire logic clk_i,
  // Events toward the slave
  output logic [10:0] ev_o,
  output logic [7:0] prm_master_o
);
  initial begin
    ev_o = 11'h000;
    prm_master_o = 8'h00;
  end
  task automatic pulse(input int idx, input logic [7:0] adr);
    @(posedge clk_i);
    ev_o <= 11'h001 << idx;
    prm_master_o <= adr;
    @(posedge clk_i);
    ev_o <= 11'h000;
    prm_master_o <= ~adr;
  endtask
endmodule

// ===== tb_fsd_diag.sv
// Self-checking bench for the slave diagnostic block.
// Assumes the bound checker and the master model beside it.
`timescale 1ns/100ps
module tb_fsd_diag;
  import fsd_pkg::*;
  logic clk_i, rst_i = 1'b1, req = 1'b0, we = 1'b0, dx = 1'b0;
  logic pend = 1'b0, ack_in = 1'b0, ack, wd;
  logic [3:0] sel = 4'h0;
  logic [7:0] adr = 8'h00, cond = 8'h00, pct = 8'h64, temp = 8'h19, pm;
  logic [7:0] s1, s2, s3, ma, ih, il, mf;
  logic [10:0] ev;
  logic [31:0] wdat = 32'h0, rdat, rd;
  int error_cnt = 0;
  int cmp_count = 0;
  int bits[6] = '{0, 2, 3, 5, 6, 7};

  fsd_master_model i_fsd_master_model (.clk_i(clk_i), .ev_o(ev),
    .prm_master_o(pm));
  fsd_diag i_fsd_diag (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(req),
    .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .prm_ok_i(ev[0]),
    .prm_rej_i(ev[1]), .prm_master_i(pm), .cfg_ok_i(ev[2]),
    .cfg_rej_i(ev[3]), .unsupp_i(ev[4]), .sync_cmd_i(ev[5]),
    .unsync_cmd_i(ev[6]), .freeze_cmd_i(ev[7]), .unfreeze_cmd_i(ev[8]),
    .data_exch_i(dx), .ext_diag_pend_i(pend), .ext_diag_ovf_i(ev[10]),
    .diag_read_i(ev[9]), .intens_low_i(cond[0]), .intens_pct_i(pct),
    .temp_c_i(temp), .hw_err_i(cond[2]), .laser_off_in_i(cond[3]),
    .speed_over_i(cond[5]), .plaus_bad_i(cond[6]),
    .switch_pass_i(cond[7]), .ack_in_i(ack_in), .stat1_o(s1),
    .stat2_o(s2), .stat3_o(s3), .master_addr_o(ma), .ident_hi_o(ih),
    .ident_lo_o(il), .malf_code_o(mf), .response_watchdog_active_o(wd));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  task settle;
    repeat (3) @(posedge clk_i);
  endtask

  task ev_do(input int i, input logic [7:0] a);
    i_fsd_master_model.pulse(i, a);
    settle;
  endtask

  // Classic single cycle; holds until ack is sampled high
  task wb(input logic w, input logic [3:0] s, input logic [7:0] a,
          input logic [31:0] d);
    @(posedge clk_i);
    req <= 1'b1;
    we <= w;
    sel <= s;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) begin
      @(posedge clk_i);
    end
    rd = rdat;
    req <= 1'b0;
  endtask

  task t_reset;
    chk("stat1", 8'h02, s1);
    chk("stat2", 8'h05, s2);
    chk("stat3", 8'h00, s3);
    chk("master", FSD_NO_MASTER, ma);
    chk("ident", FSD_IDENT, {ih, il});
    $display("t_reset done");
  endtask

  task t_prm;
    ev_do(1, 8'h00);
    chk("stat1", 8'h42, s1);
    ev_do(0, 8'h21);
    ev_do(3, 8'h00);
    chk("stat1", 8'h06, s1);
    chk("stat2", 8'h05, s2);
    ev_do(2, 8'h00);
    dx <= 1'b1;
    settle;
    chk("stat1", 8'h00, s1);
    chk("stat2", 8'h04, s2);
    ev_do(0, 8'h33);
    chk("master", 8'h21, ma);
    $display("t_prm done");
  endtask

  task t_cmd;
    ev_do(4, 8'h00);
    chk("stat1", 8'h10, s1);
    ev_do(9, 8'h00);
    ev_do(5, 8'h00);
    ev_do(7, 8'h00);
    chk("stat2", 8'h34, s2);
    ev_do(6, 8'h00);
    ev_do(8, 8'h00);
    chk("stat2", 8'h04, s2);
    ev_do(10, 8'h00);
    chk("stat3", 8'h80, s3);
    pend <= 1'b1;
    settle;
    chk("stat1", 8'h08, s1);
    pend <= 1'b0;
    ev_do(9, 8'h00);
    chk("stat1", 8'h00, {s1, s3});
    $display("t_cmd done");
  endtask

  task t_bus;
    wb(1'b1, 4'h0, FSD_OFS_CTRL, 32'h2);
    settle;
    chk("wdog", 1'b0, wd);
    wb(1'b1, 4'hF, FSD_OFS_CTRL, 32'h2);
    settle;
    chk("wdog", 8'h0D, {s2[7:1], wd});
    wb(1'b0, 4'hF, FSD_OFS_DIAG0, 32'h0);
    chk("diag0", 32'h21000C00, rd);
    wb(1'b0, 4'hF, FSD_OFS_DIAG1, 32'h0);
    chk("diag1", {FSD_IDENT[7:0], FSD_IDENT[15:8]}, rd);
    wb(1'b0, 4'hF, 8'h3C, 32'h0);
    chk("unmapped", 32'h0, rd);
    wb(1'b1, 4'hF, FSD_OFS_CTRL, 32'h0);
    $display("t_bus done");
  endtask

  task t_malf;
    wb(1'b1, 4'hF, FSD_OFS_ADDR, 32'h03);
    foreach (bits[k]) begin
      cond <= 8'h01 << bits[k];
      settle;
      chk("malf", 8'h01 << bits[k], mf);
    end
    cond <= 8'h00;
    temp <= 8'h33;
    settle;
    chk("malf", 8'h02, mf);
    temp <= 8'h32;
    pct <= 8'h0B;
    settle;
    chk("malf", 8'h10, mf);
    pct <= 8'h0C;
    wb(1'b1, 4'hF, FSD_OFS_ADDR, 32'h02);
    settle;
    chk("malf", 8'h04, mf);
    wb(1'b1, 4'hF, FSD_OFS_ADDR, 32'h63);
    wb(1'b1, 4'hF, FSD_OFS_CTRL, 32'h4);
    settle;
    chk("malf", 8'h08, mf);
    wb(1'b1, 4'hF, FSD_OFS_CTRL, 32'h8);
    settle;
    chk("malf", 8'h04, mf);
    wb(1'b1, 4'hF, FSD_OFS_CTRL, 32'h0);
    wb(1'b1, 4'hF, FSD_OFS_CTRL, 32'h1);
    cond <= 8'h80;
    settle;
    cond <= 8'h00;
    settle;
    wb(1'b0, 4'hF, FSD_OFS_MALF, 32'h0);
    chk("held", 32'h80, rd);
    wb(1'b1, 4'hF, FSD_OFS_ACK, 32'h1);
    settle;
    chk("malf", 8'h00, mf);
    cond <= 8'h20;
    settle;
    cond <= 8'h00;
    settle;
    chk("malf", 8'h20, mf);
    ack_in <= 1'b1;
    settle;
    ack_in <= 1'b0;
    chk("malf", 8'h00, mf);
    $display("t_malf done");
  endtask

  task print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    #200000;
    error_cnt++;
    print_verdict;
  end

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    t_reset;
    t_prm;
    t_cmd;
    t_bus;
    t_malf;
    print_verdict;
  end
endmodule
